//--- inc/sfb_defs.vh
// Constants of the SPI status flag bank
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH

// ----------------------------------------------------------------
// Status register addresses (7-bit)
// ----------------------------------------------------------------
`define SFB_ADDR_SUP_HI    7'h40
`define SFB_ADDR_SUP_LO    7'h41
`define SFB_ADDR_THERMAL   7'h42
`define SFB_ADDR_DEVICE    7'h43
`define SFB_ADDR_BUS       7'h44
`define SFB_ADDR_WAKE_A    7'h46
`define SFB_ADDR_WAKE_B    7'h47
`define SFB_ADDR_WAKE_LVL  7'h48
`define SFB_ADDR_PORT_OC   7'h54
`define SFB_ADDR_PORT_OL   7'h55
`define SFB_ADDR_IDENT     7'h7E

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SFB_FRAME_LEN      5'h10
`define SFB_DATA_START     5'h08
`define SFB_ADDR_MSB       6
`define SFB_MODE_BIT       7
`define SFB_CNT_IDX_MSB    3

// ----------------------------------------------------------------
// Supply-fail high byte fields
// ----------------------------------------------------------------
`define SFB_HI_BAT_UV      6
`define SFB_HI_BAT_OV      5
`define SFB_HI_REG_OV      1
`define SFB_HI_REG_WARN    0

// ----------------------------------------------------------------
// Supply-fail low byte fields
// ----------------------------------------------------------------
`define SFB_LO_POR         7
`define SFB_LO_EVT_MAP_3   4
`define SFB_LO_EVT_MAP_2   3
`define SFB_LO_EVT_MAP_1   2
`define SFB_LO_EVT_MAP_0   0

// ----------------------------------------------------------------
// Clearable masks, restart keep masks, reset values
// ----------------------------------------------------------------
`define SFB_BYTE_ZERO      8'h00
`define SFB_BYTE_ALL       8'hFF
`define SFB_HI_CLR_MASK    8'h63
`define SFB_HI_KEEP_MASK   8'h63
`define SFB_LO_CLR_MASK    8'h9D
`define SFB_LO_KEEP_MASK   8'h9D
`define SFB_LO_POR_VAL     8'h80
`define SFB_TH_CLR_MASK    8'h0F
`define SFB_TH_KEEP_MASK   8'h0F
`define SFB_DEV_CLR_MASK   8'hC3
`define SFB_DEV_KEEP_MASK  8'hCF
`define SFB_DEV_WD_LSB     2

// Identification value is arbitrary
`define SFB_IDENT_VAL      8'h5A

`endif

//--- core/sfb_sync.v
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none

module sfb_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  // Stage one feeds stage two only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // sfb_sync

`default_nettype wire

//--- core/sfb_flag_byte.v
// One status byte of latched read/clear flags plus live read-only bits
`timescale 1ns/10ps
`default_nettype none

module sfb_flag_byte #(
  parameter [7:0] CLR_MASK  = 8'hFF,
  parameter [7:0] KEEP_MASK = 8'hFF,
  parameter [7:0] RST_VAL   = 8'h00
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] set_in,
  input  wire [7:0] live_in,
  input  wire       clr,
  input  wire       soft_rst,
  input  wire       restart,
  output wire [7:0] value
);

  reg [7:0] flags;
  reg [7:0] next_flags;

  always @* begin
    next_flags = flags;
    if (soft_rst) begin
      next_flags = 8'h00;
    end else if (restart) begin
      next_flags = flags & KEEP_MASK;
    end
    if (clr) begin
      next_flags = next_flags & ~CLR_MASK;
    end
    next_flags = (next_flags | set_in) & CLR_MASK;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= RST_VAL;
    end else begin
      flags <= next_flags;
    end
  end

  // Read-only bits follow their live source
  assign value = flags | (live_in & ~CLR_MASK);

endmodule // sfb_flag_byte

`default_nettype wire

//--- core/sfb_status_bank.v
// SPI status flag bank: frame decoder, read mux and latched status bytes
//
// Functional notes
// - A status access is one 16-bit frame: 7-bit address, mode bit, then a data byte.
// - Data bits D0..D7 sit at frame positions 8..15.
// - Mode bit 7 low reads the addressed byte and changes nothing.
// - Mode bit 7 high clears the clearable flags of the addressed byte.
// - Read-only and reserved bits ignore a clear; read/clear bits are readable and clearable.
// - Flags stay latched until cleared by command; watchdog failure count is live.
// - Status bytes decode at 0x40..0x44, 0x46..0x48, 0x54, 0x55 and identification at 0x7E.
// - Supply high byte resets to zero and keeps bits 6, 5, 1, 0 on restart entry.
// - Supply high bits 7 and 4:2 read zero and ignore clears.
// - Bit 6 latches battery undervoltage, detected only with the main regulator on.
// - Bit 5 latches battery overvoltage, detected with the main regulator on or with the charge pump on.
// - Bit 1 latches main regulator overvoltage until cleared.
// - Bit 0 latches main regulator prewarning at its fixed level.
// - In stop mode undervoltage watch needs load peak or the prewarning flag.
// - Overvoltage watch runs with charge pump on, else in stop mode needs peak or prewarning.
// - The low byte power-on flag is set by power-on reset and cleared by soft reset.
`timescale 1ns/10ps
`default_nettype none
`include "sfb_defs.vh"

module sfb_status_bank (
  input  wire       CLK,
  input  wire       RST,
  input  wire       SPI_CS_N,
  input  wire       SPI_SCK,
  input  wire       SPI_MOSI,
  output reg        SPI_MISO,
  output reg        SPI_MISO_OE,
  input  wire       BAT_UV_DET,
  input  wire       BAT_OV_DET,
  input  wire       REG_OV_DET,
  input  wire       REG_PREWARN_DET,
  input  wire       REG_ENABLED,
  input  wire       STOP_MODE,
  input  wire       LOAD_PEAK,
  input  wire       CHARGE_PUMP_EN,
  input  wire       RESTART_ENTRY,
  input  wire       SOFT_RESET,
  input  wire [3:0] SUPLO_EVT,
  input  wire [3:0] THERM_EVT,
  input  wire [3:0] DEV_EVT,
  input  wire [1:0] WATCHDOG_FAILURE_COUNT_CNT,
  input  wire [7:0] BUS_EVT,
  input  wire [7:0] WAKE_A_EVT,
  input  wire [7:0] WAKE_B_EVT,
  input  wire [7:0] WAKE_LEVEL,
  input  wire [7:0] PORT_OC_EVT,
  input  wire [7:0] PORT_OL_EVT
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam       EW       = 64;
  localparam [2:0] PIN_IDLE = 3'h4;

  wire [2:0]    pin_s;
  wire [EW-1:0] evt_s;

  sfb_sync #(
    .W       (3),
    .RST_VAL (PIN_IDLE)
  ) u_pin_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  ({SPI_CS_N, SPI_SCK, SPI_MOSI}),
    .dout (pin_s)
  );

  sfb_sync #(
    .W       (EW),
    .RST_VAL ({EW{1'b0}})
  ) u_evt_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  ({BAT_UV_DET, BAT_OV_DET, REG_OV_DET, REG_PREWARN_DET,
            REG_ENABLED, STOP_MODE, LOAD_PEAK, CHARGE_PUMP_EN,
            RESTART_ENTRY, SOFT_RESET, WATCHDOG_FAILURE_COUNT_CNT,
            SUPLO_EVT, THERM_EVT, DEV_EVT,
            BUS_EVT, WAKE_A_EVT, WAKE_B_EVT, WAKE_LEVEL,
            PORT_OC_EVT}),
    .dout (evt_s)
  );

  wire       cs_n_s  = pin_s[2];
  wire       sck_s   = pin_s[1];
  wire       mosi_s  = pin_s[0];

  wire       bat_uv  = evt_s[63];
  wire       bat_ov  = evt_s[62];
  wire       reg_ov  = evt_s[61];
  wire       reg_pw  = evt_s[60];
  wire       reg_en  = evt_s[59];
  wire       stop_md = evt_s[58];
  wire       peak    = evt_s[57];
  wire       charge_pump_enable   = evt_s[56];
  wire       rst_ent = evt_s[55];
  wire       soft_in = evt_s[54];
  wire [1:0] wd_cnt  = evt_s[53:52];
  wire [3:0] lo_evt  = evt_s[51:48];
  wire [3:0] th_evt  = evt_s[47:44];
  wire [3:0] dv_evt  = evt_s[43:40];
  wire [7:0] bus_evt = evt_s[39:32];
  wire [7:0] wka_evt = evt_s[31:24];
  wire [7:0] wkb_evt = evt_s[23:16];
  wire [7:0] wk_lvl  = evt_s[15:8];
  wire [7:0] oc_evt  = evt_s[7:0];
  wire [7:0] ol_evt;

  // Open-load bits do not fit in the 64-bit event vector: own pair of flops
  sfb_sync #(
    .W       (8),
    .RST_VAL (8'h00)
  ) u_ol_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  (PORT_OL_EVT),
    .dout (ol_evt)
  );

  // ----------------------------------------------------------------
  // Mode pulses
  // ----------------------------------------------------------------
  reg  rst_ent_d;
  reg  soft_d;
  wire restart_pulse = rst_ent & ~rst_ent_d;
  wire soft_pulse    = soft_in & ~soft_d;

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rst_ent_d <= 1'b0;
      soft_d    <= 1'b0;
    end else begin
      rst_ent_d <= rst_ent;
      soft_d    <= soft_in;
    end
  end

  // ----------------------------------------------------------------
  // SPI frame engine
  // ----------------------------------------------------------------
  reg         sck_d;
  reg         cs_n_d;
  reg  [4:0]  bit_cnt;
  reg         overrun;
  reg  [15:0] frame;
  reg  [7:0]  snap;
  reg         clr_strobe;
  reg  [6:0]  clr_addr;
  reg  [7:0]  rd_byte;

  wire sck_rise  = sck_s & ~sck_d;
  wire sck_fall  = ~sck_s & sck_d;
  wire cs_start  = ~cs_n_s & cs_n_d;
  wire cs_end    = cs_n_s & ~cs_n_d;
  wire cs_active = ~cs_n_s;
  wire [6:0] addr = frame[`SFB_ADDR_MSB:0];

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_d  <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d  <= sck_s;
      cs_n_d <= cs_n_s;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt <= 5'h00;
      overrun <= 1'b0;
      frame   <= 16'h0000;
    end else if (cs_start) begin
      bit_cnt <= 5'h00;
      overrun <= 1'b0;
      frame   <= 16'h0000;
    end else if (cs_active && sck_rise) begin
      if (bit_cnt == `SFB_FRAME_LEN) begin
        overrun <= 1'b1;
      end else begin
        frame[bit_cnt[`SFB_CNT_IDX_MSB:0]] <= mosi_s;
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      SPI_MISO    <= 1'b0;
      SPI_MISO_OE <= 1'b0;
      snap        <= 8'h00;
    end else if (cs_start) begin
      SPI_MISO    <= 1'b0;
      SPI_MISO_OE <= 1'b1;
    end else if (cs_end) begin
      SPI_MISO    <= 1'b0;
      SPI_MISO_OE <= 1'b0;
    end else if (cs_active && sck_fall) begin
      if (bit_cnt == `SFB_DATA_START) begin
        snap     <= rd_byte;
        SPI_MISO <= rd_byte[0];
      end else if (bit_cnt > `SFB_DATA_START && bit_cnt < `SFB_FRAME_LEN) begin
        SPI_MISO <= snap[bit_cnt[2:0]];
      end else begin
        SPI_MISO <= 1'b0;
      end
    end
  end

  // clear only on a clean 16-bit frame with mode bit set
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      clr_strobe <= 1'b0;
      clr_addr   <= 7'h00;
    end else begin
      clr_strobe <= cs_end && (bit_cnt == `SFB_FRAME_LEN) && !overrun && frame[`SFB_MODE_BIT];
      clr_addr   <= addr;
    end
  end

  // a read frame leaves the flags alone
  wire clr_hi  = clr_strobe && (clr_addr == `SFB_ADDR_SUP_HI);
  wire clr_lo  = clr_strobe && (clr_addr == `SFB_ADDR_SUP_LO);
  wire clr_th  = clr_strobe && (clr_addr == `SFB_ADDR_THERMAL);
  wire clr_dv  = clr_strobe && (clr_addr == `SFB_ADDR_DEVICE);
  wire clr_bus = clr_strobe && (clr_addr == `SFB_ADDR_BUS);
  wire clr_wka = clr_strobe && (clr_addr == `SFB_ADDR_WAKE_A);
  wire clr_wkb = clr_strobe && (clr_addr == `SFB_ADDR_WAKE_B);
  wire clr_oc  = clr_strobe && (clr_addr == `SFB_ADDR_PORT_OC);
  wire clr_ol  = clr_strobe && (clr_addr == `SFB_ADDR_PORT_OL);

  // ----------------------------------------------------------------
  // Supply-fail high byte
  // ----------------------------------------------------------------
  wire [7:0] sup_hi;
  wire       warn_flag = sup_hi[`SFB_HI_REG_WARN];
  // stop mode needs peak load or prewarning
  wire       run_watch = ~stop_md | peak | warn_flag;
  wire       mon_uv    = reg_en & run_watch;
  // charge pump keeps overvoltage watch alive
  wire       mon_ov    = charge_pump_enable | (reg_en & run_watch);
  reg  [7:0] set_hi;

  always @* begin
    set_hi = `SFB_BYTE_ZERO;
    set_hi[`SFB_HI_BAT_UV]   = bat_uv & mon_uv;
    set_hi[`SFB_HI_BAT_OV]   = bat_ov & mon_ov;
    set_hi[`SFB_HI_REG_OV]   = reg_ov;
    set_hi[`SFB_HI_REG_WARN] = reg_pw;
  end

  // zero reset, keep mask on restart
  sfb_flag_byte #(
    .CLR_MASK  (`SFB_HI_CLR_MASK),
    .KEEP_MASK (`SFB_HI_KEEP_MASK),
    .RST_VAL   (`SFB_BYTE_ZERO)
  ) u_sup_hi (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (set_hi),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_hi),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (sup_hi)
  );

  // ----------------------------------------------------------------
  // Supply-fail low byte
  // ----------------------------------------------------------------
  wire [7:0] sup_lo;
  reg  [7:0] set_lo;

  always @* begin
    set_lo = `SFB_BYTE_ZERO;
    set_lo[`SFB_LO_EVT_MAP_3] = lo_evt[3];
    set_lo[`SFB_LO_EVT_MAP_2] = lo_evt[2];
    set_lo[`SFB_LO_EVT_MAP_1] = lo_evt[1];
    set_lo[`SFB_LO_EVT_MAP_0] = lo_evt[0];
  end

  // power-on value has the flag set, soft reset clears all
  sfb_flag_byte #(
    .CLR_MASK  (`SFB_LO_CLR_MASK),
    .KEEP_MASK (`SFB_LO_KEEP_MASK),
    .RST_VAL   (`SFB_LO_POR_VAL)
  ) u_sup_lo (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (set_lo),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_lo),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (sup_lo)
  );

  // ----------------------------------------------------------------
  // Other status bytes
  // ----------------------------------------------------------------
  wire [7:0] therm_st;
  wire [7:0] dev_st;
  wire [7:0] bus_st;
  wire [7:0] wka_st;
  wire [7:0] wkb_st;
  wire [7:0] oc_st;
  wire [7:0] ol_st;

  sfb_flag_byte #(
    .CLR_MASK  (`SFB_TH_CLR_MASK),
    .KEEP_MASK (`SFB_TH_KEEP_MASK),
    .RST_VAL   (`SFB_BYTE_ZERO)
  ) u_therm (
    .clk      (CLK),
    .rst      (RST),
    .set_in   ({4'h0, th_evt}),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_th),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (therm_st)
  );

  // watchdog count is live, not latched
  sfb_flag_byte #(
    .CLR_MASK  (`SFB_DEV_CLR_MASK),
    .KEEP_MASK (`SFB_DEV_KEEP_MASK),
    .RST_VAL   (`SFB_BYTE_ZERO)
  ) u_dev (
    .clk      (CLK),
    .rst      (RST),
    .set_in   ({dv_evt[3:2], 4'h0, dv_evt[1:0]}),
    .live_in  ({4'h0, wd_cnt, 2'h0}),
    .clr      (clr_dv),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (dev_st)
  );

  sfb_flag_byte u_bus (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (bus_evt),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_bus),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (bus_st)
  );

  sfb_flag_byte u_wka (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (wka_evt),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_wka),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (wka_st)
  );

  sfb_flag_byte u_wkb (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (wkb_evt),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_wkb),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (wkb_st)
  );

  sfb_flag_byte u_oc (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (oc_evt),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_oc),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (oc_st)
  );

  sfb_flag_byte u_ol (
    .clk      (CLK),
    .rst      (RST),
    .set_in   (ol_evt),
    .live_in  (`SFB_BYTE_ZERO),
    .clr      (clr_ol),
    .soft_rst (soft_pulse),
    .restart  (restart_pulse),
    .value    (ol_st)
  );

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // status address decode
  always @* begin
    case (addr)
      `SFB_ADDR_SUP_HI:   rd_byte = sup_hi;
      `SFB_ADDR_SUP_LO:   rd_byte = sup_lo;
      `SFB_ADDR_THERMAL:  rd_byte = therm_st;
      `SFB_ADDR_DEVICE:   rd_byte = dev_st;
      `SFB_ADDR_BUS:      rd_byte = bus_st;
      `SFB_ADDR_WAKE_A:   rd_byte = wka_st;
      `SFB_ADDR_WAKE_B:   rd_byte = wkb_st;
      `SFB_ADDR_WAKE_LVL: rd_byte = wk_lvl;
      `SFB_ADDR_PORT_OC:  rd_byte = oc_st;
      `SFB_ADDR_PORT_OL:  rd_byte = ol_st;
      `SFB_ADDR_IDENT:    rd_byte = `SFB_IDENT_VAL;
      default:            rd_byte = `SFB_BYTE_ZERO;
    endcase
  end

endmodule // sfb_status_bank

`default_nettype wire

//--- testbench/sfb_spi_master.sv
// SPI master model driving one 16-bit status frame
`timescale 1ns/10ps
`default_nettype none
module sfb_spi_master (
  input  wire logic CLK,
  input  wire logic MISO,
  output logic      CS_N,
  output logic      SCK,
  output logic      MOSI
);
  initial begin
    CS_N = 1'b1;
    SCK  = 1'b0;
    MOSI = 1'b0;
  end
  // whole frames only
  // LSB first, SCK idle low; callers enter on a CLK rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    CS_N <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      MOSI <= tx[n];
      repeat (8) @(posedge CLK);
      SCK <= 1'b1;
      rx[n] = MISO;
      repeat (8) @(posedge CLK);
      SCK <= 1'b0;
    end
    repeat (8) @(posedge CLK);
    CS_N <= 1'b1;
    // Released line shows the inverse of its last bit, never a stale copy
    MOSI <= ~tx[15];
    repeat (12) @(posedge CLK);
  endtask
endmodule // sfb_spi_master
`default_nettype wire

//--- testbench/sfb_status_bank_asserts.sv
// Checker of the SPI pin timing of the status bank
`timescale 1ns/10ps
`default_nettype none
module sfb_status_bank_asserts (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCK,
  input wire logic SPI_MISO,
  input wire logic SPI_MISO_OE
);
  logic [4:0] rises;
  logic       sck_q;
  // Raw SCK rises, counted ahead of the design's synchroniser
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rises <= 5'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= SPI_SCK;
      if (SPI_CS_N) rises <= 5'h00;
      else if (SPI_SCK && !sck_q && rises != 5'h1F) rises <= rises + 5'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_OE_RISE: assert property ($fell(SPI_CS_N) |-> ##[1:4] SPI_MISO_OE)
    else $error("output enable late after select");
  AST_OE_FALL: assert property ($rose(SPI_CS_N) |-> ##[1:4] !SPI_MISO_OE)
    else $error("output enable late to drop");
  AST_OE_HOLD: assert property (SPI_MISO_OE && !SPI_CS_N |=> SPI_MISO_OE)
    else $error("output enable dropped inside frame");
  AST_OE_QUIET: assert property (!SPI_MISO_OE && SPI_CS_N |=> !SPI_MISO_OE)
    else $error("output enable rose while deselected");
  AST_OE_IDLE: assert property (SPI_CS_N [*4] |=> !SPI_MISO_OE)
    else $error("output enable high while idle");
  AST_MISO_IDLE: assert property (SPI_CS_N [*6] |-> !SPI_MISO)
    else $error("data out not low while idle");
  AST_FIRST_BYTE: assert property (!SPI_CS_N && rises < 5'h08 |-> !SPI_MISO)
    else $error("data out high in address byte");
  AST_MISO_STEADY: assert property ((SPI_SCK && !SPI_CS_N) [*6] |=> $stable(SPI_MISO))
    else $error("data out moved while clock high");
  COV_FRAME: cover property ($rose(SPI_CS_N) && rises == 5'h10);
  COV_ONE: cover property (SPI_MISO && rises > 5'h08);
  COV_SELECT: cover property ($fell(SPI_CS_N));
endmodule // sfb_status_bank_asserts

bind sfb_status_bank sfb_status_bank_asserts u_chk (
  .CLK(CLK),
  .RST(RST),
  .SPI_CS_N(SPI_CS_N),
  .SPI_SCK(SPI_SCK),
  .SPI_MISO(SPI_MISO),
  .SPI_MISO_OE(SPI_MISO_OE)
);
`default_nettype wire

//--- testbench/sfb_status_bank_tb.sv
// Self-checking bench of the SPI status flag bank
`timescale 1ns/10ps
`default_nettype none
`include "sfb_defs.vh"
module sfb_status_bank_tb;
  logic       clk, rst, uv, ov, rov, pw, en, stop, peak, cp, rs, sr;
  logic [3:0] suplo, therm, dev;
  logic [1:0] wd;
  logic [7:0] bus, wa, wb, lvl, oc, ol;
  wire        cs_n, sck, mosi, miso, miso_oe, miso_pin;
  int         m [0:127];
  int         bad_count, checked, seed;
  logic [16:0] tbl [0:6];
  logic [6:0]  adr [0:10];
  // Undriven MISO shows a toggling pattern
  assign miso_pin = miso_oe ? miso : clk;
  sfb_spi_master mst (.CLK(clk), .MISO(miso_pin), .CS_N(cs_n), .SCK(sck), .MOSI(mosi));
  sfb_status_bank DUT (
    .CLK(clk), .RST(rst), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .BAT_UV_DET(uv), .BAT_OV_DET(ov),
    .REG_OV_DET(rov), .REG_PREWARN_DET(pw), .REG_ENABLED(en), .STOP_MODE(stop),
    .LOAD_PEAK(peak), .CHARGE_PUMP_EN(cp), .RESTART_ENTRY(rs), .SOFT_RESET(sr),
    .SUPLO_EVT(suplo), .THERM_EVT(therm), .DEV_EVT(dev), .WATCHDOG_FAILURE_COUNT_CNT(wd),
    .BUS_EVT(bus), .WAKE_A_EVT(wa), .WAKE_B_EVT(wb), .WAKE_LEVEL(lvl),
    .PORT_OC_EVT(oc), .PORT_OL_EVT(ol));
  always #5 clk = ~clk;
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input int exp, input logic [7:0] got);
    checked++;
    if (got !== exp[7:0]) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp[7:0], got);
    end
  endtask
  function automatic int exp_of(input int a);
    return m[a] | (a == 'h43 ? int'({wd, 2'h0}) : 0) | (a == 'h48 ? int'(lvl) : 0);
  endfunction
  task automatic frame(input logic [6:0] a, input logic mode, output logic [7:0] got);
    logic [15:0] rx;
    logic [7:0]  d;
    d = $random(seed);
    mst.xfer({d, mode, a}, rx);
    chk("address byte", 0, rx[7:0]);
    got = rx[15:8];
  endtask
  task automatic rd(input logic [6:0] a);
    logic [7:0] got;
    frame(a, 1'b0, got);
    chk("read byte", exp_of(a), got);
  endtask
  task automatic clr(input logic [6:0] a);
    logic [7:0] got;
    frame(a, 1'b1, got);
    chk("clear return", exp_of(a), got);
    if (a != 7'h7E) m[a] = 0;
  endtask
  task automatic ev;
    {bus, wa, wb, oc} <= $random(seed);
    {ol, therm, dev, suplo, wd} <= $random(seed);
    lvl <= $random(seed);
    {uv, ov, rov, pw} <= $random(seed);
    repeat (8) @(posedge clk);
    m['h40] |= {1'b0, uv, ov, 3'h0, rov, pw};
    m['h44] |= bus;
    m['h46] |= wa;
    m['h47] |= wb;
    m['h54] |= oc;
    m['h55] |= ol;
    m['h42] |= therm;
    m['h43] |= {dev[3:2], 4'h0, dev[1:0]};
    m['h41] |= {3'h0, suplo[3:1], 1'b0, suplo[0]};
    {bus, wa, wb, oc, ol, therm, dev, suplo} <= 52'h0;
    {uv, ov, rov, pw} <= 4'h0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    clk = 0; rst = 1; seed = 32'h8C97BAD8;
    {uv, ov, rov, pw, stop, peak, cp, rs, sr} = 9'h0;
    en = 1;
    {suplo, therm, dev, wd, bus, wa, wb, lvl, oc, ol} = 62'h0;
    foreach (m[i]) m[i] = 0;
    m['h41] = 8'h80;
    m['h7E] = `SFB_IDENT_VAL;
    tbl = '{17'h18E62, 17'h10C00, 17'h11C20, 17'h1CC00, 17'h1EC60, 17'h1C101, 17'h0CC61};
    adr = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h48, 7'h54, 7'h55, 7'h7E};
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    rd(7'h40);
    rd(7'h41);
    rd(7'h7E);
    rd(7'h45);
    clr(7'h41);
    // Table: clear first, {en,stop,peak,cp}, {uv,ov,reg ov,prewarn}, byte
    foreach (tbl[i]) begin
      if (tbl[i][16]) clr(7'h40);
      {en, stop, peak, cp} <= tbl[i][15:12];
      repeat (4) @(posedge clk);
      {uv, ov, rov, pw} <= tbl[i][11:8];
      repeat (8) @(posedge clk);
      {uv, ov, rov, pw} <= 4'h0;
      repeat (6) @(posedge clk);
      m['h40] = tbl[i][7:0];
      rd(7'h40);
    end
    {en, stop, peak, cp} <= 4'h8;
    rd(7'h40);
    clr(7'h40);
    rd(7'h40);
    repeat (3) begin
      ev();
      // Restart entry keeps every latched flag of these bytes
      rs <= 1;
      repeat (4) @(posedge clk);
      rs <= 0;
      repeat (8) @(posedge clk);
      foreach (adr[k]) rd(adr[k]);
      foreach (adr[k]) clr(adr[k]);
      foreach (adr[k]) rd(adr[k]);
    end
    ev();
    sr <= 1;
    repeat (4) @(posedge clk);
    sr <= 0;
    repeat (8) @(posedge clk);
    foreach (adr[k]) if (adr[k] != 7'h7E) m[adr[k]] = 0;
    foreach (adr[k]) rd(adr[k]);
    // Mid-run power-on reset brings the power-on flag back
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    m['h41] = 8'h80;
    rd(7'h41);
    sr <= 1;
    repeat (4) @(posedge clk);
    sr <= 0;
    repeat (8) @(posedge clk);
    m['h41] = 0;
    rd(7'h41);
    clr(7'h45);
    wrap_up();
  end
endmodule // sfb_status_bank_tb
`default_nettype wire
